// >>> rtl/pin_reset_pkg.sv
package pin_reset_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] PIN_SELECT_OFFSET = 8'h0B;
   localparam logic [7:0] UNLOCK_KEY_OFFSET = 8'h0D;
   localparam logic [7:0] SOFT_RESET_OFFSET = 8'h0F;
   localparam logic [7:0] OP_MODE_OFFSET = 8'h10;

   localparam int REG_WIDTH = 16;
   localparam int SEL_WIDTH = 5;
   localparam int SEL_LSB = 0;
   localparam int RESET_BIT_POS = 0;
   localparam int MODE_LSB = 0;

   localparam logic [4:0] PIN_SELECT_RESET = 5'h00;
   localparam logic [15:0] UNLOCK_KEY_RESET = 16'h0000;
   localparam logic [1:0] OP_MODE_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Unlock key values
   // ----------------------------------------------------------------
   localparam logic [15:0] KEY_ALWAYS = 16'h04AD;
   localparam logic [15:0] KEY_PIN_ZERO = 16'h44AD;
   localparam logic [15:0] KEY_PIN_ONE = 16'h84AD;
   localparam logic [15:0] KEY_BOTH_PINS = 16'hC4AD;

   // ----------------------------------------------------------------
   // Pin zero functions, operating modes and reset sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      FUNC_LEGACY_INT = 5'h00,
      FUNC_CFG_INT = 5'h01,
      FUNC_SLOT_WINDOW = 5'h02,
      FUNC_PULSE_A = 5'h05,
      FUNC_PULSE_B = 5'h06,
      FUNC_PULSE_AB = 5'h07,
      FUNC_DATA_A = 5'h0C,
      FUNC_DATA_B = 5'h0D,
      FUNC_DATA_AB = 5'h0E,
      FUNC_HALF_RATE = 5'h0F,
      FUNC_DRIVE_LOW = 5'h10,
      FUNC_DRIVE_HIGH = 5'h11,
      FUNC_SLOW_CLOCK = 5'h13
   } pinFunc_t;

   typedef enum logic [1:0] {
      MODE_STANDBY = 2'h0,
      MODE_PROGRAM = 2'h1,
      MODE_NORMAL = 2'h2
   } opMode_t;

   typedef enum logic [1:0] {
      RST_IDLE = 2'b00,
      RST_ACK = 2'b01,
      RST_HOLD = 2'b11,
      RST_RELEASE = 2'b10
   } resetState_t;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int SLOW_CLK_HZ = 32_000;
   localparam int SLOW_HALF_CYCLES = SYS_CLK_HZ / (2 * SLOW_CLK_HZ);
   localparam int SOFT_RESET_CYCLES = 16;

endpackage

// >>> rtl/pin_zero_if.sv
`timescale 1ns/10ps
interface pin_zero_if;
   import pin_reset_pkg::*;
   logic [4:0] funcSel;
   logic clear;
   logic legacyInt;
   logic cfgInt;
   logic slotWindow;
   logic pulseA;
   logic pulseB;
   logic dataCycleA;
   logic dataCycleB;
   logic sampleTick;
   logic slowClock;
   logic pinLevel;

   modport ctrl (output funcSel, clear, legacyInt, cfgInt, slotWindow, pulseA, pulseB,
                 output dataCycleA, dataCycleB, sampleTick, slowClock, input pinLevel);
   modport mux (input funcSel, clear, legacyInt, cfgInt, slotWindow, pulseA, pulseB,
                input dataCycleA, dataCycleB, sampleTick, slowClock, output pinLevel);
endinterface

// >>> rtl/pin_zero_mux.sv
`timescale 1ns/10ps
module pin_zero_mux
   import pin_reset_pkg::*;
(
   input wire logic clk,
   input wire logic rstN,
   pin_zero_if.mux pz
);

   logic halfRate_q;
   logic halfRate_d;
   logic level_q;
   logic level_d;

   // ----------------------------------------------------------------
   // Function selection
   // ----------------------------------------------------------------
   always_comb begin
      halfRate_d = halfRate_q;
      if (pz.clear) begin
         halfRate_d = 1'b0;
      end else if (pz.sampleTick) begin
         halfRate_d = ~halfRate_q;
      end
      level_d = 1'b0;
      case (pz.funcSel)
         FUNC_LEGACY_INT: level_d = pz.legacyInt;
         FUNC_CFG_INT: level_d = pz.cfgInt;
         FUNC_SLOT_WINDOW: level_d = pz.slotWindow;
         FUNC_PULSE_A: level_d = pz.pulseA;
         FUNC_PULSE_B: level_d = pz.pulseB;
         FUNC_PULSE_AB: level_d = pz.pulseA | pz.pulseB;
         FUNC_DATA_A: level_d = pz.dataCycleA;
         FUNC_DATA_B: level_d = pz.dataCycleB;
         FUNC_DATA_AB: level_d = pz.dataCycleA | pz.dataCycleB;
         FUNC_HALF_RATE: level_d = halfRate_q;
         FUNC_DRIVE_LOW: level_d = 1'b0;
         FUNC_DRIVE_HIGH: level_d = 1'b1;
         FUNC_SLOW_CLOCK: level_d = pz.slowClock;
         default: level_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         halfRate_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         halfRate_q <= halfRate_d;
         level_q <= level_d;
      end
   end

   assign pz.pinLevel = level_q;

endmodule

// >>> rtl/soft_reset_seq.sv
`timescale 1ns/10ps
module soft_reset_seq
   import pin_reset_pkg::*;
#(
   parameter int HOLD_CYCLES = SOFT_RESET_CYCLES
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic start,
   output logic busy,
   output logic resetActive
);

   localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

   initial begin
      if (HOLD_CYCLES < 1) begin
         $error("soft_reset_seq: HOLD_CYCLES must be at least one");
      end
   end

   resetState_t state_q;
   resetState_t state_d;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         RST_IDLE: begin
            if (start) begin
               state_d = RST_ACK;
            end
         end
         RST_ACK: begin
            state_d = RST_HOLD;
            count_d = CNT_W'(HOLD_CYCLES - 1);
         end
         RST_HOLD: begin
            if (count_q == '0) begin
               state_d = RST_RELEASE;
            end else begin
               count_d = count_q - 1'b1;
            end
         end
         RST_RELEASE: state_d = RST_IDLE;
         default: state_d = RST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_q <= RST_IDLE;
         count_q <= '0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
      end
   end

   assign busy = (state_q != RST_IDLE);
   assign resetActive = (state_q == RST_HOLD);

endmodule

// >>> rtl/pin_select_reset_mode_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - Five-bit pin zero function selector in bits 4..0, reset zero.
// - Selector zero drives pin zero with legacy interrupt behaviour.
// - Selector one drives pin zero with the configured interrupt.
// - Selector two: high from first slot start to last slot end.
// - Codes five, six, seven output slot A, slot B, both LED pulses.
// - Codes twelve to fourteen mark data cycles for A, B, either.
// - Code fifteen toggles pin zero every sample, half sample rate.
// - Code sixteen drives low, seventeen high; other codes unsupported.
// - Code nineteen routes the 32 kHz oscillator onto pin zero.
// - Sixteen-bit unlock key, reset zero; 0x04AD always permits address change.
// - Keys 0x44AD, 0x84AD, 0xC4AD permit change on pin zero, one, both high.
// - Writing one to reset bit resets device; bit clears when finished.
// - The reset write is acknowledged first, then defaults and standby.
// - Two-bit mode field: zero standby, one program.
module pin_select_reset_mode_regs
   import pin_reset_pkg::*;
#(
   parameter int RESET_HOLD_CYCLES = SOFT_RESET_CYCLES,
   parameter int SLOW_HALF = SLOW_HALF_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [15:0] regRdData,
   output logic regRdValid,
   output logic regWrAck,
   input wire logic legacyIntIn,
   input wire logic cfgIntIn,
   input wire logic slotWindowIn,
   input wire logic ledPulseA,
   input wire logic ledPulseB,
   input wire logic dataCycleA,
   input wire logic dataCycleB,
   input wire logic sampleTick,
   input wire logic auxPinOne,
   output logic auxPinZero,
   output logic addrChangeEnable,
   output logic [1:0] opMode,
   output logic modeStandby,
   output logic modeProgram,
   output logic modeNormal,
   output logic deviceReset
);

   localparam int SLOW_W = $clog2(SLOW_HALF + 1);

   initial begin
      if (SLOW_HALF < 1) begin
         $error("pin_select_reset_mode_regs: SLOW_HALF must be at least one");
      end
      if (RESET_HOLD_CYCLES < 1) begin
         $error("pin_select_reset_mode_regs: RESET_HOLD_CYCLES must be at least one");
      end
   end

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rstSync1_q;
   logic rstSync2_q;
   logic rstN;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end

   assign rstN = rstSync2_q;

   // ----------------------------------------------------------------
   // Pin one synchroniser
   // ----------------------------------------------------------------
   logic pinOneMeta_q;
   logic pinOneSync_q;

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         pinOneMeta_q <= 1'b0;
         pinOneSync_q <= 1'b0;
      end else begin
         pinOneMeta_q <= auxPinOne;
         pinOneSync_q <= pinOneMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // Software reset sequencer
   // ----------------------------------------------------------------
   logic resetStart;
   logic resetBusy;
   logic resetActive;

   assign resetStart = regWrEn && (regAddr == SOFT_RESET_OFFSET) && regWrData[RESET_BIT_POS] && !resetBusy;

   soft_reset_seq #(
      .HOLD_CYCLES(RESET_HOLD_CYCLES)
   ) resetSeq (
      .clk(clk_sys),
      .rstN(rstN),
      .start(resetStart),
      .busy(resetBusy),
      .resetActive(resetActive)
   );

   // ----------------------------------------------------------------
   // Slow oscillator divider
   // ----------------------------------------------------------------
   logic [SLOW_W-1:0] slowCount_q;
   logic [SLOW_W-1:0] slowCount_d;
   logic slowLevel_q;
   logic slowLevel_d;

   always_comb begin
      slowCount_d = slowCount_q;
      slowLevel_d = slowLevel_q;
      if (slowCount_q == SLOW_W'(SLOW_HALF - 1)) begin
         slowCount_d = '0;
         slowLevel_d = ~slowLevel_q;
      end else begin
         slowCount_d = slowCount_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         slowCount_q <= '0;
         slowLevel_q <= 1'b0;
      end else begin
         slowCount_q <= slowCount_d;
         slowLevel_q <= slowLevel_d;
      end
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [4:0] pinSelect_q;
   logic [4:0] pinSelect_d;
   logic [15:0] unlockKey_q;
   logic [15:0] unlockKey_d;
   logic [1:0] mode_q;
   logic [1:0] mode_d;
   logic writeOk;

   assign writeOk = regWrEn && !resetBusy;

   always_comb begin
      pinSelect_d = pinSelect_q;
      unlockKey_d = unlockKey_q;
      mode_d = mode_q;
      if (resetActive) begin
         pinSelect_d = PIN_SELECT_RESET;
         unlockKey_d = UNLOCK_KEY_RESET;
         mode_d = OP_MODE_RESET;
      end else if (writeOk) begin
         if (regAddr == PIN_SELECT_OFFSET) begin
            pinSelect_d = regWrData[SEL_LSB +: SEL_WIDTH];
         end else if (regAddr == UNLOCK_KEY_OFFSET) begin
            unlockKey_d = regWrData;
         end else if (regAddr == OP_MODE_OFFSET) begin
            mode_d = regWrData[MODE_LSB +: 2];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         pinSelect_q <= PIN_SELECT_RESET;
         unlockKey_q <= UNLOCK_KEY_RESET;
         mode_q <= OP_MODE_RESET;
      end else begin
         pinSelect_q <= pinSelect_d;
         unlockKey_q <= unlockKey_d;
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   logic [15:0] rdData_q;
   logic [15:0] rdData_d;
   logic rdValid_q;
   logic wrAck_q;

   always_comb begin
      rdData_d = 16'h0000;
      if (regAddr == PIN_SELECT_OFFSET) begin
         rdData_d[SEL_LSB +: SEL_WIDTH] = pinSelect_q;
      end else if (regAddr == UNLOCK_KEY_OFFSET) begin
         rdData_d = unlockKey_q;
      end else if (regAddr == SOFT_RESET_OFFSET) begin
         rdData_d[RESET_BIT_POS] = resetBusy;
      end else if (regAddr == OP_MODE_OFFSET) begin
         rdData_d[MODE_LSB +: 2] = mode_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         rdData_q <= 16'h0000;
         rdValid_q <= 1'b0;
         wrAck_q <= 1'b0;
      end else begin
         rdData_q <= regRdEn ? rdData_d : rdData_q;
         rdValid_q <= regRdEn;
         wrAck_q <= regWrEn;
      end
   end

   assign regRdData = rdData_q;
   assign regRdValid = rdValid_q;
   assign regWrAck = wrAck_q;

   // ----------------------------------------------------------------
   // Pin zero function
   // ----------------------------------------------------------------
   pin_zero_if pz ();

   assign pz.funcSel = pinSelect_q;
   assign pz.clear = resetActive;
   assign pz.legacyInt = legacyIntIn;
   assign pz.cfgInt = cfgIntIn;
   assign pz.slotWindow = slotWindowIn;
   assign pz.pulseA = ledPulseA;
   assign pz.pulseB = ledPulseB;
   assign pz.dataCycleA = dataCycleA;
   assign pz.dataCycleB = dataCycleB;
   assign pz.sampleTick = sampleTick;
   assign pz.slowClock = slowLevel_q;

   pin_zero_mux pinMux (
      .clk(clk_sys),
      .rstN(rstN),
      .pz(pz)
   );

   assign auxPinZero = pz.pinLevel;

   // ----------------------------------------------------------------
   // Address change permission
   // ----------------------------------------------------------------
   logic addrEnable_q;
   logic addrEnable_d;

   always_comb begin
      addrEnable_d = 1'b0;
      if (unlockKey_q == KEY_ALWAYS) begin
         addrEnable_d = 1'b1;
      end else if (unlockKey_q == KEY_PIN_ZERO) begin
         addrEnable_d = pz.pinLevel;
      end else if (unlockKey_q == KEY_PIN_ONE) begin
         addrEnable_d = pinOneSync_q;
      end else if (unlockKey_q == KEY_BOTH_PINS) begin
         addrEnable_d = pz.pinLevel & pinOneSync_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         addrEnable_q <= 1'b0;
      end else begin
         addrEnable_q <= addrEnable_d;
      end
   end

   assign addrChangeEnable = addrEnable_q;

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   assign opMode = mode_q;
   assign modeStandby = (mode_q == MODE_STANDBY);
   assign modeProgram = (mode_q == MODE_PROGRAM);
   assign modeNormal = (mode_q == MODE_NORMAL);
   assign deviceReset = resetActive;

endmodule

// >>> tb/host_model.sv
`timescale 1ns/10ps
module host_model (
   input wire logic clk,
   output logic [7:0] addr,
   output logic [15:0] wrData,
   output logic wrEn,
   output logic rdEn,
   input wire logic [15:0] rdData,
   input wire logic rdValid,
   input wire logic wrAck
);
   // ----------------------------------------------------------------
   // Register port accesses
   // ----------------------------------------------------------------
   initial begin
      addr = 8'h00;
      wrData = 16'h0000;
      wrEn = 1'b0;
      rdEn = 1'b0;
   end

   task automatic wrReg(input logic [7:0] a, input logic [15:0] d, output logic ok);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
      wrData <= ~d;
      // The acknowledge stands in the cycle after the strobe and is taken at the edge that samples it.
      @(posedge clk);
      ok = wrAck;
   endtask

   task automatic rdReg(input logic [7:0] a, output logic [15:0] v, output logic ok);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      @(posedge clk);
      v = rdData;
      ok = rdValid;
   endtask
endmodule

// >>> tb/pin_select_reset_mode_regs_chk.sv
`timescale 1ns/10ps
module pin_select_reset_mode_regs_chk
   import pin_reset_pkg::*;
#(
   parameter int RESET_HOLD_CYCLES = SOFT_RESET_CYCLES,
   parameter int SLOW_HALF = SLOW_HALF_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [15:0] regRdData,
   input wire logic regRdValid,
   input wire logic regWrAck,
   input wire logic auxPinZero,
   input wire logic addrChangeEnable,
   input wire logic [1:0] opMode,
   input wire logic modeStandby,
   input wire logic modeProgram,
   input wire logic modeNormal,
   input wire logic deviceReset
);
   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   logic rstWrQ;
   logic devRstQ;
   logic [7:0] rstCnt;
   logic quiet;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rstWrQ <= 1'b0;
         devRstQ <= 1'b0;
         rstCnt <= 8'h00;
      end else begin
         rstWrQ <= regWrEn && regAddr == SOFT_RESET_OFFSET && regWrData[0];
         devRstQ <= deviceReset;
         rstCnt <= deviceReset ? rstCnt + 8'h01 : 8'h00;
      end
   end
   // Writes near a software reset may be dropped, so they are not judged.
   assign quiet = !deviceReset && !devRstQ && !rstWrQ;

   property p_wrAck;
      regWrAck == $past(regWrEn);
   endproperty
   a_wrAck: assert property (p_wrAck) else $error("write ack not one cycle after strobe");
   property p_rdValid;
      regRdEn |=> regRdValid;
   endproperty
   a_rdValid: assert property (p_rdValid) else $error("read valid missing");
   property p_rdSel;
      regRdEn && regAddr == PIN_SELECT_OFFSET |=> regRdData[15:5] == 11'h000;
   endproperty
   a_rdSel: assert property (p_rdSel) else $error("selector reads spare bits");
   property p_rdMode;
      regRdEn && regAddr == OP_MODE_OFFSET |=> regRdData[15:2] == 14'h0000;
   endproperty
   a_rdMode: assert property (p_rdMode) else $error("mode reads spare bits");
   property p_keyAlways;
      regWrEn && regAddr == UNLOCK_KEY_OFFSET && regWrData == KEY_ALWAYS && quiet |-> ##2 addrChangeEnable;
   endproperty
   a_keyAlways: assert property (p_keyAlways) else $error("unconditional key did not unlock");
   property p_pinFixed;
      regWrEn && regAddr == PIN_SELECT_OFFSET && regWrData[4:1] == 4'h8 && quiet
         |-> ##2 auxPinZero == $past(regWrData[0], 2);
   endproperty
   a_pinFixed: assert property (p_pinFixed) else $error("fixed pin level wrong");
   property p_rstStart;
      regWrEn && regAddr == SOFT_RESET_OFFSET && regWrData[0] && !deviceReset && !devRstQ
         |-> ##[1:2] deviceReset;
   endproperty
   a_rstStart: assert property (p_rstStart) else $error("software reset did not start");
   property p_rstLen;
      $fell(deviceReset) && rstCnt != 8'h00 |-> rstCnt == 8'(RESET_HOLD_CYCLES);
   endproperty
   a_rstLen: assert property (p_rstLen) else $error("software reset length wrong");
   property p_rstDefault;
      $fell(deviceReset) |-> ##1 (opMode == 2'h0 && modeStandby && !addrChangeEnable);
   endproperty
   a_rstDefault: assert property (p_rstDefault) else $error("defaults not restored");
   property p_modeDecode;
      $stable(opMode) |-> modeStandby == (opMode == MODE_STANDBY) && modeProgram == (opMode == MODE_PROGRAM)
         && modeNormal == (opMode == MODE_NORMAL);
   endproperty
   a_modeDecode: assert property (p_modeDecode) else $error("mode decode wrong");

   c_softReset: cover property ($rose(deviceReset));
   c_unlock: cover property ($rose(addrChangeEnable));
   c_pinHigh: cover property ($rose(auxPinZero));
endmodule

bind pin_select_reset_mode_regs pin_select_reset_mode_regs_chk #(
   .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES),
   .SLOW_HALF(SLOW_HALF)
) chkInst (.*);

// >>> tb/pin_select_reset_mode_regs_bench.sv
`timescale 1ns/10ps
module pin_select_reset_mode_regs_bench;
   import pin_reset_pkg::*;
   logic clk_sys;
   logic rst_n;
   logic [7:0] regAddr;
   logic [15:0] regWrData;
   logic regWrEn;
   logic regRdEn;
   logic [15:0] regRdData;
   logic regRdValid;
   logic regWrAck;
   logic [6:0] src;
   logic sampleTick;
   logic auxPinOne;
   logic auxPinZero;
   logic addrChangeEnable;
   logic [1:0] opMode;
   logic modeStandby;
   logic modeProgram;
   logic modeNormal;
   logic deviceReset;
   int fails;
   int samplesChecked;
   logic [7:0] offs [4] = '{PIN_SELECT_OFFSET, UNLOCK_KEY_OFFSET, SOFT_RESET_OFFSET, OP_MODE_OFFSET};
   logic [4:0] codes [12] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0C, 5'h0D, 5'h0E, 5'h10, 5'h11, 5'h03};
   // Key, selector, pin one level, expected unlock.
   logic [31:0] keys [9] = '{32'h04AD_1001, 32'h44AD_1010, 32'h44AD_1101, 32'h84AD_1100, 32'h84AD_1011,
                             32'hC4AD_1010, 32'hC4AD_1111, 32'hC4AD_1100, 32'h14AD_1110};

   pin_select_reset_mode_regs #(.RESET_HOLD_CYCLES(2), .SLOW_HALF(4)) pin_select_reset_mode_regs_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid), .regWrAck(regWrAck),
      .legacyIntIn(src[0]), .cfgIntIn(src[1]), .slotWindowIn(src[2]), .ledPulseA(src[3]), .ledPulseB(src[4]),
      .dataCycleA(src[5]), .dataCycleB(src[6]), .sampleTick(sampleTick), .auxPinOne(auxPinOne),
      .auxPinZero(auxPinZero), .addrChangeEnable(addrChangeEnable), .opMode(opMode), .modeStandby(modeStandby),
      .modeProgram(modeProgram), .modeNormal(modeNormal), .deviceReset(deviceReset));

   host_model host_model_inst (.clk(clk_sys), .addr(regAddr), .wrData(regWrData), .wrEn(regWrEn),
      .rdEn(regRdEn), .rdData(regRdData), .rdValid(regRdValid), .wrAck(regWrAck));

   // ----------------------------------------------------------------
   // Checking tasks
   // ----------------------------------------------------------------
   function automatic logic pinExp(input logic [4:0] c, input logic [6:0] s);
      case (c)
         5'h00: pinExp = s[0];
         5'h01: pinExp = s[1];
         5'h02: pinExp = s[2];
         5'h05: pinExp = s[3];
         5'h06: pinExp = s[4];
         5'h07: pinExp = s[3] | s[4];
         5'h0C: pinExp = s[5];
         5'h0D: pinExp = s[6];
         5'h0E: pinExp = s[5] | s[6];
         5'h11: pinExp = 1'b1;
         default: pinExp = 1'b0;
      endcase
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic ok;
      host_model_inst.wrReg(a, d, ok);
      chk({15'h0000, ok}, 16'h0001);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] v;
      logic ok;
      host_model_inst.rdReg(a, v, ok);
      chk({15'h0000, ok}, 16'h0001);
      chk(v, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   initial begin
      int n;
      logic prev;
      fails = 0;
      samplesChecked = 0;
      rst_n = 1'b0;
      src = 7'h00;
      sampleTick = 1'b0;
      auxPinOne = 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      settle(3);
      foreach (offs[j]) rd(offs[j], 16'h0000);
      chk({13'h0000, modeNormal, modeProgram, modeStandby}, 16'h0001);
      wr(8'h20, 16'hFFFF);
      rd(8'h20, 16'h0000);
      wr(PIN_SELECT_OFFSET, 16'hFFF3);
      rd(PIN_SELECT_OFFSET, 16'h0013);
      wr(OP_MODE_OFFSET, 16'hFFFF);
      rd(OP_MODE_OFFSET, 16'h0003);
      chk({13'h0000, modeNormal, modeProgram, modeStandby}, 16'h0000);
      for (int m = 0; m < 3; m++) begin
         wr(OP_MODE_OFFSET, 16'(m));
         chk({13'h0000, modeNormal, modeProgram, modeStandby}, 16'h0001 << m);
      end
      for (int i = 0; i < 12; i++) begin
         wr(PIN_SELECT_OFFSET, {11'h000, codes[i]});
         for (int p = 0; p < 9; p++) begin
            @(posedge clk_sys);
            src <= p < 7 ? 7'h01 << p : {7{p == 7}};
            settle(2);
            chk({15'h0000, auxPinZero}, {15'h0000, pinExp(codes[i], src)});
         end
      end
      wr(PIN_SELECT_OFFSET, 16'h000F);
      settle(1);
      for (int k = 0; k < 3; k++) begin
         prev = auxPinZero;
         @(posedge clk_sys);
         sampleTick <= 1'b1;
         @(posedge clk_sys);
         sampleTick <= 1'b0;
         settle(2);
         chk({15'h0000, auxPinZero}, {15'h0000, ~prev});
      end
      wr(PIN_SELECT_OFFSET, 16'h0013);
      settle(2);
      prev = auxPinZero;
      n = 0;
      for (int k = 0; k < 40; k++) begin
         settle(1);
         if (auxPinZero !== prev) n++;
         prev = auxPinZero;
      end
      chk(16'(n), 16'h000A);
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_sys);
         auxPinOne <= keys[i][4];
         wr(PIN_SELECT_OFFSET, {8'h00, keys[i][15:8]});
         wr(UNLOCK_KEY_OFFSET, keys[i][31:16]);
         settle(3);
         chk({15'h0000, addrChangeEnable}, {15'h0000, keys[i][0]});
      end
      rd(UNLOCK_KEY_OFFSET, 16'h14AD);
      wr(OP_MODE_OFFSET, 16'h0002);
      wr(UNLOCK_KEY_OFFSET, KEY_ALWAYS);
      wr(SOFT_RESET_OFFSET, 16'h0001);
      rd(SOFT_RESET_OFFSET, 16'h0001);
      for (n = 0; n < 20 && deviceReset !== 1'b0; n++) settle(1);
      // A reset that never ends counts as a mismatch and the run still reaches the report.
      if (n == 20) begin
         fails++;
      end
      settle(2);
      chk({11'h000, opMode, modeStandby, addrChangeEnable, auxPinZero}, 16'h0004);
      foreach (offs[j]) rd(offs[j], 16'h0000);
      print_verdict();
   end
endmodule
